// >>> design/qpfe_pkg.sv
// Constants and types for the four-phase fetch/execute pipeline control
// Operation
// - Oscillator clock divided by four into four non-overlapping phases in fixed order.
// - One instruction cycle is exactly one pass through phases one to four.
// - Program counter increments in phase one, starting a fetch cycle.
// - Instruction word read and captured into fetch latch in phase four.
// - Fetch overlaps execute; non-branching instructions complete one per cycle.
// - Fetched word moves to instruction register in phase one, executes phases two-four.
// - Operand read in phase two, destination written in phase four.
// - Program-counter-changing instructions take two cycles; all others take one.
// - Taken branch discards prefetched word; target fetched in extra cycle.
package qpfe_pkg;
  localparam int          PC_W      = 13;
  localparam int          INSTR_W   = 14;
  localparam logic [12:0] RESET_PC  = 13'h0000;
  localparam logic [13:0] NOP_WORD  = 14'h0000;
  localparam logic [12:0] PC_STEP   = 13'h0001;

  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } phase_t;
endpackage : qpfe_pkg

// >>> design/phase_gen.sv
// Four-phase divider producing one-cycle phase enables
`timescale 1ns/1ps
module phase_gen
  import qpfe_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rstn,
  output logic      phase_one,
  output logic      phase_two,
  output logic      phase_three,
  output logic      phase_four
);
  typedef struct packed {
    phase_t ph;
  } pg_state_t;

  pg_state_t s_q;
  pg_state_t s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.ph)
      PH_ONE:   s_d.ph = PH_TWO;
      PH_TWO:   s_d.ph = PH_THREE;
      PH_THREE: s_d.ph = PH_FOUR;
      PH_FOUR:  s_d.ph = PH_ONE;
      default:  s_d.ph = PH_ONE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q.ph <= PH_ONE;
    end else begin
      s_q <= s_d;
    end
  end

  // Decoded from state; exactly one phase active per cycle
  assign phase_one   = (s_q.ph == PH_ONE);
  assign phase_two   = (s_q.ph == PH_TWO);
  assign phase_three = (s_q.ph == PH_THREE);
  assign phase_four  = (s_q.ph == PH_FOUR);

  property p_phase_order;
    @(posedge mclk) disable iff (!rstn)
      phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
  endproperty
  a_phase_order: assert property (p_phase_order)
    else $error("phase order broken");

  property p_one_hot;
    @(posedge mclk) disable iff (!rstn)
      $onehot({phase_one, phase_two, phase_three, phase_four});
  endproperty
  a_one_hot: assert property (p_one_hot)
    else $error("phases overlap");
endmodule : phase_gen

// >>> design/quad_phase_fetch_execute.sv
// Two-stage fetch/execute pipeline sequenced by four phase enables
`timescale 1ns/1ps
module quad_phase_fetch_execute
  import qpfe_pkg::*;
#(
  parameter int ADDR_W = PC_W,
  parameter int WORD_W = INSTR_W
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic [WORD_W-1:0] prog_rdata,
  input  wire logic              branch_taken,
  input  wire logic [ADDR_W-1:0] branch_target,
  output logic [ADDR_W-1:0]      prog_addr,
  output logic                   prog_rd,
  output logic [WORD_W-1:0]      instr_word,
  output logic                   exec_valid,
  output logic                   operand_rd,
  output logic                   dest_wr,
  output logic                   instr_done,
  output logic [1:0]             phase_out
);
  // Reset and step constants are sized by the package, so other widths cannot be served
  if (ADDR_W != PC_W || WORD_W != INSTR_W) begin : g_bad_width
    $error("widths must match package");
  end

  logic phase_one;
  logic phase_two;
  logic phase_three;
  logic phase_four;

  phase_gen u_phase (
    .mclk        (mclk),
    .rstn        (rstn),
    .phase_one   (phase_one),
    .phase_two   (phase_two),
    .phase_three (phase_three),
    .phase_four  (phase_four)
  );

  typedef struct packed {
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] fetch_pc;
    logic [WORD_W-1:0] fetch_latch;
    logic              fetch_valid;
    logic [WORD_W-1:0] ir;
    logic        ir_valid;
    logic        flush;
    logic        prog_rd;
    logic        operand_rd;
    logic        dest_wr;
    logic        done;
    logic [1:0]  ph;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d            = s_q;
    s_d.prog_rd    = 1'b0;
    s_d.operand_rd = 1'b0;
    s_d.dest_wr    = 1'b0;
    s_d.done       = 1'b0;
    s_d.ph         = {phase_three | phase_four, phase_two | phase_four};
    if (phase_one) begin
      // Fetch stage: address held through the cycle, then step
      s_d.fetch_pc = s_q.pc;
      s_d.pc       = s_q.pc + PC_STEP;
      // Execute stage takes the prefetched word; a flushed one is dropped
      s_d.ir       = s_q.fetch_latch;
      s_d.ir_valid = s_q.fetch_valid & ~s_q.flush;
      s_d.flush    = 1'b0;
    end
    if (phase_two && s_q.ir_valid) begin
      s_d.operand_rd = 1'b1;
    end
    if (phase_three) begin
      s_d.prog_rd = 1'b1;
    end
    if (phase_four) begin
      s_d.fetch_latch = prog_rdata;
      s_d.fetch_valid = 1'b1;
      if (s_q.ir_valid) begin
        s_d.dest_wr = 1'b1;
        s_d.done    = 1'b1;
        // Branch redirects the counter; the word fetched now is stale
        if (branch_taken) begin
          s_d.pc    = branch_target;
          s_d.flush = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q.pc          <= RESET_PC;
      s_q.fetch_pc    <= RESET_PC;
      s_q.fetch_latch <= NOP_WORD;
      s_q.fetch_valid <= 1'b0;
      s_q.ir          <= NOP_WORD;
      s_q.ir_valid    <= 1'b0;
      s_q.flush       <= 1'b0;
      s_q.prog_rd     <= 1'b0;
      s_q.operand_rd  <= 1'b0;
      s_q.dest_wr     <= 1'b0;
      s_q.done        <= 1'b0;
      s_q.ph          <= 2'h0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  assign prog_addr  = s_q.fetch_pc;
  assign prog_rd    = s_q.prog_rd;
  assign instr_word = s_q.ir;
  assign exec_valid = s_q.ir_valid;
  assign operand_rd = s_q.operand_rd;
  assign dest_wr    = s_q.dest_wr;
  assign instr_done = s_q.done;
  assign phase_out  = s_q.ph;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_pc_step;
    @(posedge mclk) disable iff (!rstn)
      (phase_one && !$past(phase_four && s_q.ir_valid && branch_taken))
        |=> s_q.pc == $past(s_q.pc) + PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("pc did not step in phase one");

  property p_latch;
    @(posedge mclk) disable iff (!rstn)
      phase_four |=> s_q.fetch_latch == $past(prog_rdata);
  endproperty
  a_latch: assert property (p_latch)
    else $error("fetch latch missed word");

  property p_ir_load;
    @(posedge mclk) disable iff (!rstn)
      phase_one |=> s_q.ir == $past(s_q.fetch_latch);
  endproperty
  a_ir_load: assert property (p_ir_load)
    else $error("ir not loaded in phase one");

  property p_operand;
    @(posedge mclk) disable iff (!rstn)
      operand_rd |-> exec_valid ##2 dest_wr;
  endproperty
  a_operand: assert property (p_operand)
    else $error("operand/dest timing wrong");

  property p_throughput;
    @(posedge mclk) disable iff (!rstn)
      (instr_done && s_q.fetch_valid && !$past(branch_taken)) |-> ##4 instr_done;
  endproperty
  a_throughput: assert property (p_throughput)
    else $error("non-branch did not complete next cycle");

  property p_branch_flush;
    @(posedge mclk) disable iff (!rstn)
      (phase_four && s_q.ir_valid && branch_taken)
        |=> ##1 !exec_valid [*4] ##1 exec_valid;
  endproperty
  a_branch_flush: assert property (p_branch_flush)
    else $error("prefetched word not discarded");

  property p_branch_target;
    @(posedge mclk) disable iff (!rstn)
      (phase_four && s_q.ir_valid && branch_taken)
        |=> ##1 prog_addr == $past(branch_target, 2);
  endproperty
  a_branch_target: assert property (p_branch_target)
    else $error("target not fetched in extra cycle");

  property p_reset_empty;
    @(posedge mclk) $rose(rstn) |-> !exec_valid && !dest_wr;
  endproperty
  a_reset_empty: assert property (p_reset_empty)
    else $error("execute stage not empty after reset");
endmodule : quad_phase_fetch_execute

// >>> testbench/prog_mem_model.sv
// Program memory model answering every fetch address
`timescale 1ns/1ps
module prog_mem_model
  import qpfe_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic [PC_W-1:0]    prog_addr,
  output logic      [INSTR_W-1:0] prog_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // Word tracks its address, so the bench can tell which address was executed.
  // It trails the address by one edge; the address stands for four clocks.
  initial prog_rdata = 14'h0000;
  always @(posedge mclk) begin
    prog_rdata <= {1'b1, prog_addr};
  end
endmodule : prog_mem_model

// >>> testbench/test_quad_phase_fetch_execute.sv
// Testbench for the four-phase fetch/execute pipeline
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((ex) !== (gt)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module test_quad_phase_fetch_execute
  import qpfe_pkg::*;
;
  logic         mclk          = 1'b0;
  logic         rstn          = 1'b0;
  logic         branch_taken  = 1'b0;
  logic [12:0]  branch_target = 13'h0000;
  logic [13:0]  prog_rdata;
  logic [12:0]  prog_addr;
  logic         prog_rd;
  logic [13:0]  instr_word;
  logic         exec_valid;
  logic         operand_rd;
  logic         dest_wr;
  logic         instr_done;
  logic [1:0]   phase_out;
  logic [1:0]   ph_last;
  logic [13:0]  word_exp;
  int           error_cnt     = 0;
  int           checks        = 0;
  int           prd;
  int           ord;
  int           dwr;
  int           evl;

  always #50 mclk = ~mclk;

  quad_phase_fetch_execute uut (.mclk(mclk), .rstn(rstn), .prog_rdata(prog_rdata),
    .branch_taken(branch_taken), .branch_target(branch_target), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .instr_word(instr_word), .exec_valid(exec_valid),
    .operand_rd(operand_rd), .dest_wr(dest_wr), .instr_done(instr_done),
    .phase_out(phase_out));

  prog_mem_model mem (.mclk(mclk), .prog_addr(prog_addr), .prog_rdata(prog_rdata));

  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Counts clocks and strobes up to the next completion; bounded wait
  task wait_done(output int n);
    n   = 0;
    prd = 0;
    ord = 0;
    dwr = 0;
    evl = 0;
    do begin
      @(posedge mclk);
      n++;
      `CHK("phase_out", 2'(ph_last + 2'd1), phase_out)
      ph_last = phase_out;
      prd += int'(prog_rd);
      ord += int'(operand_rd);
      dwr += int'(dest_wr);
      evl += int'(exec_valid !== 1'b1);
      if (n > 20) begin
        error_cnt++;
        end_of_test();
      end
    end while (instr_done !== 1'b1);
  endtask : wait_done

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    repeat (2) @(posedge mclk);
    `CHK("prog_addr", 13'h0000, prog_addr)
    `CHK("exec_valid", 1'b0, exec_valid)
    rstn          <= 1'b1;
    // Raised while the execute stage is still empty, so it must be ignored
    branch_taken  <= 1'b1;
    branch_target <= 13'h00aa;
    repeat (5) @(posedge mclk);
    branch_taken <= 1'b0;
    ph_last = 2'd3;
    wait_done(n);
    `CHK("first_len", 4, n)
    `CHK("instr_word", 14'h2000, instr_word)
    `CHK("prog_addr", 13'h0001, prog_addr)
    word_exp = instr_word;
    for (int i = 0; i < 3; i++) begin
      wait_done(n);
      word_exp = word_exp + 14'h0001;
      `CHK("cycle_len", 4, n)
      `CHK("instr_word", word_exp, instr_word)
      `CHK("prog_rd", 1, prd)
      `CHK("operand_rd", 1, ord)
      `CHK("dest_wr", 1, dwr)
      `CHK("exec_gap", 0, evl)
    end
    // Held over a whole cycle so the phase-four edge surely sees it
    branch_taken  <= 1'b1;
    branch_target <= 13'h0155;
    wait_done(n);
    branch_taken <= 1'b0;
    `CHK("branch_len", 4, n)
    wait_done(n);
    `CHK("flush_len", 8, n)
    `CHK("instr_word", 14'h2155, instr_word)
    `CHK("dest_wr", 1, dwr)
    `CHK("operand_rd", 1, ord)
    `CHK("flush_gap", 4, evl)
    `CHK("prog_addr", 13'h0156, prog_addr)
    wait_done(n);
    `CHK("cycle_len", 4, n)
    `CHK("instr_word", 14'h2156, instr_word)
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("exec_valid", 1'b0, exec_valid)
    `CHK("phase_out", 2'd0, phase_out)
    `CHK("dest_wr", 1'b0, dest_wr)
    end_of_test();
  end
endmodule : test_quad_phase_fetch_execute
